// ===== inc/flash_poll_defs.svh
// Constants of the flash status poller: register map, fields, codes and timing.
`ifndef FLASH_POLL_DEFS_SVH
`define FLASH_POLL_DEFS_SVH

// ****************************************
// Register offsets on the Avalon-MM slave.
// ****************************************
`define FP_REG_CTRL     5'h00
`define FP_REG_ADDR     5'h04
`define FP_REG_WDATA    5'h08
`define FP_REG_STAT     5'h0C

// ****************************************
// Control fields, operation and result codes.
// ****************************************
`define FP_CTRL_OP_LSB  0
`define FP_CTRL_OP_MSB  1
`define FP_CTRL_AUTORST 2
`define FP_CTRL_ABORT   3
`define FP_OP_NONE      2'h0
`define FP_OP_READ      2'h1
`define FP_OP_WRITE     2'h2
`define FP_OP_POLL      2'h3
`define FP_RES_NONE     2'h0
`define FP_RES_PASS     2'h1
`define FP_RES_FAIL     2'h2
`define FP_RES_ABORT    2'h3

// ****************************************
// Status bit positions in a byte read from the flash.
// ****************************************
`define FP_DQ_POLL      7
`define FP_DQ_TOGGLE    6
`define FP_DQ_TMO       5
`define FP_DQ_ETOG      2

// ****************************************
// Reset values and command codes.
// ****************************************
`define FP_ADDR_RST     19'h00000
`define FP_WDATA_RST    8'h00
`define FP_RESET_CMD    8'hF0

// ****************************************
// Bus cycle timing in ns and derived clock counts.
// ****************************************
`define FP_CLK_NS       100
`define FP_SETUP_NS     100
`define FP_STROBE_NS    200
`define FP_RECOV_NS     100
`define FP_SETUP_CYC    ((`FP_SETUP_NS + `FP_CLK_NS - 1) / `FP_CLK_NS)
`define FP_STROBE_CYC   ((`FP_STROBE_NS + `FP_CLK_NS - 1) / `FP_CLK_NS)
`define FP_RECOV_CYC    ((`FP_RECOV_NS + `FP_CLK_NS - 1) / `FP_CLK_NS)

`endif

// ===== inc/flash_poll_pkg.sv
// Types shared by the flash status poller modules.
package flash_poll_pkg;

  typedef struct packed {
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic        dq_oe_n;
    logic [18:0] addr;
    logic [7:0]  dq;
  } flash_pins_t;

  typedef struct packed {
    logic        start;
    logic        wr;
    logic [18:0] addr;
    logic [7:0]  wdata;
  } bus_req_t;

  typedef struct packed {
    logic toggled;
    logic etoggled;
    logic err;
  } tog_t;

  typedef enum logic [3:0] {
    CYC_IDLE   = 4'h1,
    CYC_SETUP  = 4'h2,
    CYC_STROBE = 4'h4,
    CYC_RECOV  = 4'h8
  } cyc_state_t;

  typedef struct packed {
    cyc_state_t  st;
    logic [3:0]  cnt;
    logic [7:0]  rdata;
    logic        done;
    flash_pins_t pins;
  } cyc_regs_t;

  typedef enum logic [7:0] {
    C_IDLE = 8'h01,
    C_CYC  = 8'h02,
    C_RD1  = 8'h04,
    C_RD2  = 8'h08,
    C_RD3  = 8'h10,
    C_RD4  = 8'h20,
    C_FIN  = 8'h40,
    C_RST  = 8'h80
  } ctl_state_t;

  typedef struct packed {
    ctl_state_t  st;
    logic        pend;
    logic        cwr;
    logic        ack;
    logic [31:0] rdata;
    logic [18:0] addr;
    logic [7:0]  wdata;
    logic        auto_rst;
    logic        abort;
    logic        busy;
    logic        done;
    logic [1:0]  result;
    logic        etog;
    logic        err;
    logic [7:0]  s1;
    logic [7:0]  rbyte;
    logic [15:0] loops;
  } ctl_regs_t;

endpackage : flash_poll_pkg

// ===== hdl/flash_bus_cycle.sv
// One read or write cycle on the flash pins, strobed by chip-select and output-enable or write-strobe.
`timescale 1ns/10ps
`include "flash_poll_defs.svh"
module flash_bus_cycle (
  input  wire logic                       ref_clk_i,
  input  wire logic                       rst_i,
  input  wire flash_poll_pkg::bus_req_t   req_i,
  input  wire logic [7:0]                 dq_i,
  output flash_poll_pkg::flash_pins_t     pins_o,
  output logic [7:0]                      rdata_o,
  output logic                            done_o
);

  flash_poll_pkg::cyc_regs_t q, d;

  always_comb begin
    d      = q;
    d.done = 1'b0;
    case (q.st)
      flash_poll_pkg::CYC_IDLE: begin
        if (req_i.start) begin
          d.pins.addr    = req_i.addr;
          d.pins.dq      = req_i.wdata;
          d.pins.ce_n    = 1'b0;
          d.pins.dq_oe_n = ~req_i.wr;
          d.cnt          = 4'(`FP_SETUP_CYC - 1);
          d.st           = flash_poll_pkg::CYC_SETUP;
        end
      end
      flash_poll_pkg::CYC_SETUP: begin
        if (q.cnt == 4'h0) begin
          d.pins.oe_n = ~q.pins.dq_oe_n;
          d.pins.we_n = q.pins.dq_oe_n;
          d.cnt       = 4'(`FP_STROBE_CYC - 1);
          d.st        = flash_poll_pkg::CYC_STROBE;
        end else begin
          d.cnt = q.cnt - 4'h1;
        end
      end
      flash_poll_pkg::CYC_STROBE: begin
        if (q.cnt == 4'h0) begin
          d.rdata     = dq_i;
          d.pins.oe_n = 1'b1;
          d.pins.we_n = 1'b1;
          d.cnt       = 4'(`FP_RECOV_CYC - 1);
          d.st        = flash_poll_pkg::CYC_RECOV;
        end else begin
          d.cnt = q.cnt - 4'h1;
        end
      end
      flash_poll_pkg::CYC_RECOV: begin
        if (q.cnt == 4'h0) begin
          d.pins.ce_n    = 1'b1;
          d.pins.dq_oe_n = 1'b1;
          d.done         = 1'b1;
          d.st           = flash_poll_pkg::CYC_IDLE;
        end else begin
          d.cnt = q.cnt - 4'h1;
        end
      end
      default: begin
        d.st = flash_poll_pkg::CYC_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      q.st           <= flash_poll_pkg::CYC_IDLE;
      q.cnt          <= 4'h0;
      q.rdata        <= 8'h00;
      q.done         <= 1'b0;
      q.pins.ce_n    <= 1'b1;
      q.pins.oe_n    <= 1'b1;
      q.pins.we_n    <= 1'b1;
      q.pins.dq_oe_n <= 1'b1;
      q.pins.addr    <= `FP_ADDR_RST;
      q.pins.dq      <= `FP_WDATA_RST;
    end else begin
      q <= d;
    end
  end

  assign pins_o  = q.pins;
  assign rdata_o = q.rdata;
  assign done_o  = q.done;

endmodule : flash_bus_cycle

// ===== hdl/flash_toggle_cmp.sv
// Compares two successive status reads for toggling and the error flag.
`timescale 1ns/10ps
`include "flash_poll_defs.svh"
module flash_toggle_cmp (
  input  wire logic [7:0]          first_i,
  input  wire logic [7:0]          second_i,
  output flash_poll_pkg::tog_t     tog_o
);

  always_comb begin
    tog_o.toggled  = first_i[`FP_DQ_TOGGLE] ^ second_i[`FP_DQ_TOGGLE];
    tog_o.etoggled = first_i[`FP_DQ_ETOG] ^ second_i[`FP_DQ_ETOG];
    tog_o.err      = second_i[`FP_DQ_TMO];
  end

endmodule : flash_toggle_cmp

// ===== hdl/flash_status_poller.sv
// Host controller that issues flash bus cycles and runs the toggle-bit status poll.
//
// The Avalon-MM register port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`include "flash_poll_defs.svh"

// Summary of operation
// - Host writes reset command after timeout error.
// - Host compares two consecutive reads' toggle bits.
// - On toggling, check error, then retest toggle.
// - Resumed polling restarts full two-read check.
module flash_status_poller #(
  parameter logic [7:0] RESET_CMD = `FP_RESET_CMD
) (
  input  wire logic                       ref_clk_i,
  input  wire logic                       rst_i,
  input  wire logic [4:0]                 avs_address_i,
  input  wire logic                       avs_read_i,
  input  wire logic                       avs_write_i,
  input  wire logic [31:0]                avs_writedata_i,
  input  wire logic [3:0]                 avs_byteenable_i,
  output logic [31:0]                     avs_readdata_o,
  output logic                            avs_waitrequest_o,
  output flash_poll_pkg::flash_pins_t     flash_o,
  input  wire logic [7:0]                 dq_i
);

  // ****************************************
  // Register helpers.
  // ****************************************

  function automatic logic [31:0] be_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  be
  );
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : be_merge

  function automatic logic [31:0] reg_read(
    input flash_poll_pkg::ctl_regs_t r,
    input logic [4:0]                a
  );
    logic [31:0] v;
    v = 32'h00000000;
    if (a == `FP_REG_CTRL) begin
      v[`FP_CTRL_AUTORST] = r.auto_rst;
    end else if (a == `FP_REG_ADDR) begin
      v[18:0] = r.addr;
    end else if (a == `FP_REG_WDATA) begin
      v[7:0] = r.wdata;
    end else if (a == `FP_REG_STAT) begin
      v[0]     = r.busy;
      v[1]     = r.done;
      v[3:2]   = r.result;
      v[4]     = r.etog;
      v[5]     = r.err;
      v[15:8]  = r.rbyte;
      v[31:16] = r.loops;
    end
    return v;
  endfunction : reg_read

  // ****************************************
  // State and submodule wiring.
  // ****************************************

  flash_poll_pkg::ctl_regs_t q, d;
  flash_poll_pkg::bus_req_t  breq;
  flash_poll_pkg::tog_t      tog;
  logic [7:0]                brdata;
  logic                      bdone;
  logic [31:0]               wval;
  logic                      wr_now;

  always_comb begin
    breq.start = q.pend;
    breq.wr    = q.cwr;
    breq.addr  = q.addr;
    if (q.st == flash_poll_pkg::C_RST) begin
      breq.wdata = RESET_CMD;
    end else begin
      breq.wdata = q.wdata;
    end
  end

  flash_bus_cycle u_cycle (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .req_i     (breq),
    .dq_i      (dq_i),
    .pins_o    (flash_o),
    .rdata_o   (brdata),
    .done_o    (bdone)
  );

  flash_toggle_cmp u_cmp (
    .first_i  (q.s1),
    .second_i (brdata),
    .tog_o    (tog)
  );

  // ****************************************
  // Register slave and poll sequencer.
  // ****************************************

  always_comb begin
    d      = q;
    d.pend = 1'b0;
    d.ack  = 1'b0;
    wr_now = avs_write_i && q.ack;
    wval   = be_merge(reg_read(q, avs_address_i), avs_writedata_i, avs_byteenable_i);

    if ((avs_read_i || avs_write_i) && !q.ack) begin
      d.ack   = 1'b1;
      d.rdata = reg_read(q, avs_address_i);
    end

    if (wr_now) begin
      if (avs_address_i == `FP_REG_ADDR) begin
        d.addr = wval[18:0];
      end else if (avs_address_i == `FP_REG_WDATA) begin
        d.wdata = wval[7:0];
      end else if (avs_address_i == `FP_REG_CTRL) begin
        d.auto_rst = wval[`FP_CTRL_AUTORST];
        if (wval[`FP_CTRL_ABORT] && q.busy) begin
          d.abort = 1'b1;
        end
        if (!q.busy && (wval[`FP_CTRL_OP_MSB:`FP_CTRL_OP_LSB] != `FP_OP_NONE)) begin
          d.busy   = 1'b1;
          d.done   = 1'b0;
          d.result = `FP_RES_NONE;
          d.loops  = 16'h0000;
          d.etog   = 1'b0;
          d.err    = 1'b0;
          d.abort  = 1'b0;
          d.pend   = 1'b1;
          d.cwr    = (wval[`FP_CTRL_OP_MSB:`FP_CTRL_OP_LSB] == `FP_OP_WRITE);
          if (wval[`FP_CTRL_OP_MSB:`FP_CTRL_OP_LSB] == `FP_OP_POLL) begin
            d.st = flash_poll_pkg::C_RD1;
          end else begin
            d.st = flash_poll_pkg::C_CYC;
          end
        end
      end
    end

    case (q.st)
      flash_poll_pkg::C_IDLE: begin
        d.cwr = d.cwr;
      end
      flash_poll_pkg::C_CYC: begin
        if (bdone) begin
          if (!q.cwr) begin
            d.rbyte = brdata;
          end
          d.result = `FP_RES_PASS;
          d.busy   = 1'b0;
          d.done   = 1'b1;
          d.st     = flash_poll_pkg::C_IDLE;
        end
      end
      flash_poll_pkg::C_RD1: begin
        if (bdone) begin
          d.s1    = brdata;
          d.rbyte = brdata;
          d.pend  = 1'b1;
          d.st    = flash_poll_pkg::C_RD2;
        end
      end
      flash_poll_pkg::C_RD2: begin
        if (bdone) begin
          d.rbyte = brdata;
          if (!tog.toggled) begin
            d.pend = 1'b1;
            d.st   = flash_poll_pkg::C_FIN;
          end else begin
            if (tog.etoggled) begin
              d.etog = 1'b1;
            end
            if (tog.err) begin
              d.err  = 1'b1;
              d.pend = 1'b1;
              d.st   = flash_poll_pkg::C_RD3;
            end else if (q.abort) begin
              d.result = `FP_RES_ABORT;
              d.busy   = 1'b0;
              d.done   = 1'b1;
              d.st     = flash_poll_pkg::C_IDLE;
            end else begin
              d.loops = q.loops + 16'h0001;
              d.pend  = 1'b1;
              d.st    = flash_poll_pkg::C_RD1;
            end
          end
        end
      end
      flash_poll_pkg::C_RD3: begin
        if (bdone) begin
          d.s1    = brdata;
          d.rbyte = brdata;
          d.pend  = 1'b1;
          d.st    = flash_poll_pkg::C_RD4;
        end
      end
      flash_poll_pkg::C_RD4: begin
        if (bdone) begin
          d.rbyte = brdata;
          if (!tog.toggled) begin
            d.pend = 1'b1;
            d.st   = flash_poll_pkg::C_FIN;
          end else if (q.auto_rst) begin
            d.pend = 1'b1;
            d.cwr  = 1'b1;
            d.st   = flash_poll_pkg::C_RST;
          end else begin
            d.result = `FP_RES_FAIL;
            d.busy   = 1'b0;
            d.done   = 1'b1;
            d.st     = flash_poll_pkg::C_IDLE;
          end
        end
      end
      flash_poll_pkg::C_FIN: begin
        if (bdone) begin
          d.rbyte  = brdata;
          d.result = `FP_RES_PASS;
          d.busy   = 1'b0;
          d.done   = 1'b1;
          d.st     = flash_poll_pkg::C_IDLE;
        end
      end
      flash_poll_pkg::C_RST: begin
        if (bdone) begin
          d.result = `FP_RES_FAIL;
          d.cwr    = 1'b0;
          d.busy   = 1'b0;
          d.done   = 1'b1;
          d.st     = flash_poll_pkg::C_IDLE;
        end
      end
      default: begin
        d.st   = flash_poll_pkg::C_IDLE;
        d.busy = 1'b0;
      end
    endcase
  end

  // ****************************************
  // State register.
  // ****************************************

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      q.st       <= flash_poll_pkg::C_IDLE;
      q.pend     <= 1'b0;
      q.cwr      <= 1'b0;
      q.ack      <= 1'b0;
      q.rdata    <= 32'h00000000;
      q.addr     <= `FP_ADDR_RST;
      q.wdata    <= `FP_WDATA_RST;
      q.auto_rst <= 1'b0;
      q.abort    <= 1'b0;
      q.busy     <= 1'b0;
      q.done     <= 1'b0;
      q.result   <= `FP_RES_NONE;
      q.etog     <= 1'b0;
      q.err      <= 1'b0;
      q.s1       <= 8'h00;
      q.rbyte    <= 8'h00;
      q.loops    <= 16'h0000;
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // Bus outputs.
  // ****************************************

  assign avs_readdata_o    = q.rdata;
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !q.ack;

endmodule : flash_status_poller

// ===== tb/flash_poll_chk.sv
// Concurrent checks on the flash pins and register bus of the status poller.
`timescale 1ns/10ps
module flash_poll_chk (
  input  wire logic                        ref_clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        avs_read_i,
  input  wire logic                        avs_write_i,
  input  wire logic                        avs_waitrequest_o,
  input  wire flash_poll_pkg::flash_pins_t flash_o
);
  // **********
  // Properties.
  // **********
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_low2(logic s);
    !s ##1 !s ##1 s;
  endsequence
  property p_wait_hi;
    $rose(avs_read_i) || $rose(avs_write_i) |-> avs_waitrequest_o;
  endproperty
  a_wait_hi: assert property (p_wait_hi) else $error("request not held in its first cycle");
  property p_wait_one;
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("request held for more than one cycle");
  property p_rd_pulse;
    $fell(flash_o.oe_n) |-> s_low2(flash_o.oe_n);
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe not two cycles");
  property p_wr_pulse;
    $fell(flash_o.we_n) |-> s_low2(flash_o.we_n);
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe not two cycles");
  property p_rd_cs;
    $fell(flash_o.oe_n) |-> !flash_o.ce_n && flash_o.we_n && flash_o.dq_oe_n;
  endproperty
  a_rd_cs: assert property (p_rd_cs) else $error("read strobe outside a clean read frame");
  property p_wr_drive;
    !flash_o.we_n |-> !flash_o.ce_n && !flash_o.dq_oe_n && flash_o.oe_n;
  endproperty
  a_wr_drive: assert property (p_wr_drive) else $error("write strobe without driven data");
  property p_ce_lead;
    $fell(flash_o.ce_n) |=> $fell(flash_o.oe_n) || $fell(flash_o.we_n);
  endproperty
  a_ce_lead: assert property (p_ce_lead) else $error("strobe not one cycle after select");
  property p_ce_trail;
    $rose(flash_o.oe_n) || $rose(flash_o.we_n) |=> $rose(flash_o.ce_n);
  endproperty
  a_ce_trail: assert property (p_ce_trail) else $error("select not released after strobe");
  property p_addr_hold;
    !flash_o.ce_n |=> flash_o.ce_n || $stable(flash_o.addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved inside a frame");
  property p_gap;
    $rose(flash_o.ce_n) |=> flash_o.ce_n;
  endproperty
  a_gap: assert property (p_gap) else $error("frames too close");
endmodule : flash_poll_chk
bind flash_status_poller flash_poll_chk flash_poll_chk_i (
  .ref_clk_i(ref_clk_i),
  .rst_i(rst_i),
  .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i),
  .avs_waitrequest_o(avs_waitrequest_o),
  .flash_o(flash_o)
);

// ===== tb/flash_dev_model.sv
// Behavioural byte-wide flash that reports embedded operation status on reads.
`timescale 1ns/10ps
`include "flash_poll_defs.svh"
module flash_dev_model (
  input  wire flash_poll_pkg::flash_pins_t pins_i,
  output logic [7:0]                       dq_o
);
  logic [7:0] arr_q = 8'hFF;
  logic [7:0] last_q = 8'h00;
  logic       tog_q = 1'b0;
  logic       etog_q = 1'b0;
  logic       err_q = 1'b0;
  logic       ers_q = 1'b0;
  logic       rst_seen = 1'b0;
  int         left_q = 0;
  wire        rd = !pins_i.ce_n && !pins_i.oe_n;
  wire        wr = !pins_i.ce_n && !pins_i.we_n;
  // **********
  // Status word and read cycles.
  // **********
  function automatic logic [7:0] stat();
    logic [7:0] v;
    if (left_q == 0) return arr_q;
    v = arr_q;
    v[7] = ers_q ? 1'b0 : ~arr_q[7];
    v[6] = tog_q;
    v[5] = err_q;
    if (ers_q) v[2] = etog_q;
    return v;
  endfunction : stat
  // The busy span is counted in reads, so short and long toggling both exist.
  task automatic start(input int n, input logic e, input logic s);
    left_q = n;
    err_q = e;
    ers_q = s;
  endtask : start
  always_comb dq_o = rd ? stat() : ~last_q;
  always @(negedge rd) begin
    last_q = stat();
    if (left_q > 0) begin
      tog_q = ~tog_q;
      etog_q = ~etog_q;
      left_q = left_q - 1;
    end
  end
  // A real strobe ends with select still low; the edge seen at reset has select high.
  always @(negedge wr) begin
    if (!pins_i.ce_n && (pins_i.dq == `FP_RESET_CMD)) begin
      left_q = 0;
      err_q = 1'b0;
      rst_seen = 1'b1;
    end else if (!pins_i.ce_n && (left_q == 0)) begin
      ers_q = 1'b0;
      if ((pins_i.dq & ~arr_q) != 8'h00) begin
        err_q = 1'b1;
        left_q = 1000000;
      end else begin
        arr_q = pins_i.dq;
        left_q = 2;
      end
    end
  end
endmodule : flash_dev_model

// ===== tb/flash_status_poller_tb.sv
// Self-checking bench of the flash status poller against a flash model.
`timescale 1ns/10ps
`include "flash_poll_defs.svh"
module flash_status_poller_tb;
  logic                        ref_clk = 1'b0;
  logic                        rst = 1'b1;
  logic [4:0]                  avs_address = 5'h00;
  logic                        avs_read = 1'b0;
  logic                        avs_write = 1'b0;
  logic [31:0]                 avs_writedata = 32'h0;
  logic [31:0]                 avs_readdata;
  logic                        avs_waitrequest;
  flash_poll_pkg::flash_pins_t pins;
  logic [7:0]                  dq;
  logic [31:0]                 q;
  logic [31:0]                 a;
  logic [7:0]                  d;
  int                          bad_count = 0;
  int                          total_checks = 0;
  always #50 ref_clk = ~ref_clk;
  flash_status_poller flash_status_poller_i (
    .ref_clk_i(ref_clk),
    .rst_i(rst),
    .avs_address_i(avs_address),
    .avs_read_i(avs_read),
    .avs_write_i(avs_write),
    .avs_writedata_i(avs_writedata),
    .avs_byteenable_i(4'hF),
    .avs_readdata_o(avs_readdata),
    .avs_waitrequest_o(avs_waitrequest),
    .flash_o(pins),
    .dq_i(dq)
  );
  flash_dev_model flash_dev_model_i (
    .pins_i(pins),
    .dq_o(dq)
  );
  // **********
  // Bus tasks and expected status words.
  // **********
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic av(input logic w, input logic [4:0] ad, input logic [31:0] wd);
    @(posedge ref_clk);
    avs_address <= ad;
    avs_writedata <= wd;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : av
  task automatic run(input logic [3:0] ctl);
    av(1'b1, `FP_REG_CTRL, {28'h0, ctl});
    do av(1'b0, `FP_REG_STAT, 32'h0); while (q[1:0] !== 2'b10);
  endtask : run
  function automatic logic [31:0] ex(input logic [1:0] r, input logic et, input logic er, input logic [7:0] b,
                                     input int n);
    return {16'(n), b, 2'b00, er, et, r, 2'b10};
  endfunction : ex
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done
  initial begin
    #3000000;
    bad_count++;
    test_done();
  end
  // **********
  // Scenarios.
  // **********
  initial begin
    void'($urandom(18));
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    chk("select idle", 32'h1, {31'h0, pins.ce_n});
    for (int i = 0; i < 5; i++) begin
      av(1'b0, 5'(i * 4), 32'h0);
      chk("reset value", 32'h0, q);
    end
    a = $urandom;
    d = 8'($urandom) & 8'h7E;
    av(1'b1, 5'h10, $urandom);
    av(1'b1, `FP_REG_STAT, 32'hFFFFFFFF);
    av(1'b0, `FP_REG_STAT, 32'h0);
    chk("status write", 32'h0, q);
    av(1'b1, `FP_REG_ADDR, a);
    av(1'b0, `FP_REG_ADDR, 32'h0);
    chk("address", a & 32'h7FFFF, q);
    av(1'b1, `FP_REG_WDATA, {24'h0, d});
    run(4'h2);
    chk("programmed", {24'h0, d}, {24'h0, flash_dev_model_i.arr_q});
    chk("flash address", a & 32'h7FFFF, {13'h0, pins.addr});
    run(4'h3);
    chk("program poll", ex(`FP_RES_PASS, 1'b0, 1'b0, d, 1), q);
    for (int m = 1; m < 4; m++) begin
      flash_dev_model_i.start(2 * m, 1'b0, 1'b1);
      run(4'h3);
      chk("erase poll", ex(`FP_RES_PASS, 1'b1, 1'b0, d, m), q);
    end
    flash_dev_model_i.start(2, 1'b1, 1'b1);
    run(4'h3);
    chk("late stop", ex(`FP_RES_PASS, 1'b1, 1'b1, d, 0), q);
    run(4'h3);
    chk("idle poll", ex(`FP_RES_PASS, 1'b0, 1'b0, d, 0), q);
    av(1'b1, `FP_REG_WDATA, {24'h0, ~d});
    run(4'h2);
    run(4'h7);
    chk("fail poll", ex(`FP_RES_FAIL, 1'b0, 1'b1, 8'h00, 0), q & 32'hFFFF00FF);
    chk("reset command", 32'h1, {31'h0, flash_dev_model_i.rst_seen});
    chk("array kept", {24'h0, d}, {24'h0, flash_dev_model_i.arr_q});
    flash_dev_model_i.start(100000, 1'b0, 1'b0);
    av(1'b1, `FP_REG_CTRL, 32'h3);
    repeat (40) @(posedge ref_clk);
    run(4'h8);
    chk("abort", ex(`FP_RES_ABORT, 1'b0, 1'b0, 8'h00, 0) & 32'hFF, q & 32'hFF);
    flash_dev_model_i.start(8, 1'b1, 1'b0);
    run(4'h3);
    chk("fail no reset", ex(`FP_RES_FAIL, 1'b0, 1'b1, 8'h00, 0), q & 32'hFFFF00FF);
    flash_dev_model_i.start(0, 1'b0, 1'b0);
    run(4'h1);
    chk("array read", {24'h0, d}, {24'h0, q[15:8]});
    test_done();
  end
endmodule : flash_status_poller_tb
